// *** verilog/pio_lines_pkg.sv ***
/*
  Constants, register map and carrier types of the parallel line controller.
  Assumes a 32-bit Avalon-MM slave with byte addresses and one core clock.
*/
// Behaviour
// - Filter-on write 1 enables line filter
// - Filter-off write 1 disables line filter
// - Filter state reads 1 when enabled
// - Drive-set write 1 makes drive value 1
// - Drive-clear write 1 makes drive value 0
// - Drive state reads scheduled drive value
// - Drive state read-only or writable per line
// - Pin level reads actual line level
// - Irq-on write 1 enables change interrupt
// - Irq-off write 1 disables change interrupt
// - Mask state reads 1 while enabled
// - Change status set by detected level change
// - Open-drain-on write 1 selects multi-drive
// - Open-drain-off write 1 restores push-pull
// - Open-drain lines drive low only
// - Pull-up-off write 1 disables pull-up
// - Pull-up-on write 1 enables pull-up
// - Pull-up state reads 0 when on
// - Select-first write 1 picks peripheral A
// - Select-second write 1 picks peripheral B
// - Drive state writes honour write permission
// - Reading change status clears it
// - Interrupt is OR of status bits ANDed with mask
// - Choice state reads 1 for peripheral B
package pio_lines_pkg;

  localparam int LINES = 32;
  localparam int ADDR_W = 8;

  // Lines that exist in this instance
  localparam logic [31:0] IMPL_MASK = 32'hFFFF_FFFF;

  localparam logic [7:0] OFF_OUT_ON = 8'h10;
  localparam logic [7:0] OFF_OUT_OFF = 8'h14;
  localparam logic [7:0] OFF_OUT_STATE = 8'h18;
  localparam logic [7:0] OFF_FILT_ON = 8'h20;
  localparam logic [7:0] OFF_FILT_OFF = 8'h24;
  localparam logic [7:0] OFF_FILT_STATE = 8'h28;
  localparam logic [7:0] OFF_DRV_SET = 8'h30;
  localparam logic [7:0] OFF_DRV_CLR = 8'h34;
  localparam logic [7:0] OFF_DRV_STATE = 8'h38;
  localparam logic [7:0] OFF_PIN_LEVEL = 8'h3C;
  localparam logic [7:0] OFF_IRQ_ON = 8'h40;
  localparam logic [7:0] OFF_IRQ_OFF = 8'h44;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h48;
  localparam logic [7:0] OFF_CHG_STATUS = 8'h4C;
  localparam logic [7:0] OFF_OD_ON = 8'h50;
  localparam logic [7:0] OFF_OD_OFF = 8'h54;
  localparam logic [7:0] OFF_OD_STATE = 8'h58;
  localparam logic [7:0] OFF_PU_OFF = 8'h60;
  localparam logic [7:0] OFF_PU_ON = 8'h64;
  localparam logic [7:0] OFF_PU_STATE = 8'h68;
  localparam logic [7:0] OFF_ALT_A = 8'h70;
  localparam logic [7:0] OFF_ALT_B = 8'h74;
  localparam logic [7:0] OFF_ALT_STATE = 8'h78;
  localparam logic [7:0] OFF_PERMIT_ON = 8'hA0;
  localparam logic [7:0] OFF_PERMIT_OFF = 8'hA4;
  localparam logic [7:0] OFF_PERMIT_STATE = 8'hA8;

  localparam logic [31:0] RST_LINE_REGS = 32'h0000_0000;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

  // Edges after reset before change detection starts
  localparam logic [1:0] SETTLE_RST = 2'h0;
  localparam logic [1:0] SETTLE_DONE = 2'h3;

  // Slave handshake states, Gray order
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ANSWER = 2'b01
  } bus_state_t;

  typedef struct packed {
    logic [31:0] level;
    logic [31:0] enable;
  } pad_drive_t;

  typedef struct packed {
    logic [31:0] pullup_on;
    logic [31:0] periph_b;
    logic [31:0] filter_on;
  } line_cfg_t;

endpackage

// *** verilog/line_input_stage.sv ***
/*
  Per-line input path: two-flop synchroniser, optional glitch filter and
  change detection. Assumes pad_in is asynchronous to core_clk.
*/
`timescale 1ns/1ps
module line_input_stage
  import pio_lines_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [LINES-1:0] pad_in,
  input wire logic [LINES-1:0] filter_on,
  output logic [LINES-1:0] level,
  output logic [LINES-1:0] changed
);

  logic [LINES-1:0] meta_r;
  logic [LINES-1:0] sync_r;
  logic [LINES-1:0] prev_r;
  logic [LINES-1:0] level_r;
  logic [LINES-1:0] level_nxt;
  logic [LINES-1:0] changed_r;
  logic [1:0] settle_r;

  // No false change while the synchroniser still holds reset zeros
  wire settled = (settle_r == SETTLE_DONE);
  wire [1:0] settle_nxt = settled ? SETTLE_DONE : settle_r + 2'h1;
  wire [LINES-1:0] edge_seen;

  genvar i;
  generate
    for (i = 0; i < LINES; i++) begin : g_line
      // Filter passes a level only after it held for two samples
      assign level_nxt[i] = (filter_on[i] && (sync_r[i] != prev_r[i])) ? level_r[i] : sync_r[i];
    end
  endgenerate

  assign edge_seen = settled ? (level_nxt ^ level_r) : RST_LINE_REGS;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      meta_r <= RST_LINE_REGS;
      sync_r <= RST_LINE_REGS;
      prev_r <= RST_LINE_REGS;
      level_r <= RST_LINE_REGS;
      changed_r <= RST_LINE_REGS;
      settle_r <= SETTLE_RST;
    end else begin
      meta_r <= pad_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
      level_r <= level_nxt;
      changed_r <= edge_seen;
      settle_r <= settle_nxt;
    end
  end

  assign level = level_r;
  assign changed = changed_r;

endmodule

// *** verilog/pio_lines.sv ***
/*
  Register file and pad control of a 32-line parallel controller.
  Assumes an Avalon-MM master with waitrequest, and pads that resolve
  level, enable and pull-up outside this module.
*/
`timescale 1ns/1ps
module pio_lines
  import pio_lines_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [LINES-1:0] pad_in,
  output pad_drive_t pad_drive,
  output line_cfg_t line_cfg,
  output logic irq
);

  function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] off);
    hit = (addr == off);
  endfunction

  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  bus_state_t state_r;
  bus_state_t state_nxt;
  logic [31:0] readdata_r;

  logic [31:0] out_en_r;
  logic [31:0] filter_r;
  logic [31:0] drive_r;
  logic [31:0] irq_mask_r;
  logic [31:0] chg_r;
  logic [31:0] od_r;
  logic [31:0] pu_off_r;
  logic [31:0] alt_b_r;
  logic [31:0] permit_r;
  logic irq_r;

  logic [31:0] out_en_nxt;
  logic [31:0] filter_nxt;
  logic [31:0] drive_nxt;
  logic [31:0] irq_mask_nxt;
  logic [31:0] chg_nxt;
  logic [31:0] od_nxt;
  logic [31:0] pu_off_nxt;
  logic [31:0] alt_b_nxt;
  logic [31:0] permit_nxt;

  logic [LINES-1:0] pin_level;
  logic [LINES-1:0] pin_changed;

  line_input_stage u_inputs (
    .core_clk(core_clk),
    .srst(srst),
    .pad_in(pad_in),
    .filter_on(filter_r),
    .level(pin_level),
    .changed(pin_changed)
  );

  // Bus handshake: one wait cycle, answer on the second
  wire req = avs_read | avs_write;
  wire capture = req && (state_r == BUS_IDLE);
  wire accept = req && (state_r == BUS_ANSWER);
  assign avs_waitrequest = req && (state_r != BUS_ANSWER);
  assign avs_readdata = readdata_r;

  always_comb begin
    case (state_r)
      BUS_IDLE: state_nxt = req ? BUS_ANSWER : BUS_IDLE;
      BUS_ANSWER: state_nxt = BUS_IDLE;
      default: state_nxt = BUS_IDLE;
    endcase
  end

  // Write data limited to enabled lanes and existing lines
  wire [31:0] wmask = lane_mask(avs_byteenable) & IMPL_MASK;
  wire [31:0] wbits = avs_writedata & wmask;
  wire wr = accept && avs_write;
  wire [ADDR_W-1:0] a = avs_address;

  wire [31:0] w_out_on = (wr && hit(a, OFF_OUT_ON)) ? wbits : READ_ZERO;
  wire [31:0] w_out_off = (wr && hit(a, OFF_OUT_OFF)) ? wbits : READ_ZERO;
  wire [31:0] w_filt_on = (wr && hit(a, OFF_FILT_ON)) ? wbits : READ_ZERO;
  wire [31:0] w_filt_off = (wr && hit(a, OFF_FILT_OFF)) ? wbits : READ_ZERO;
  wire [31:0] w_drv_set = (wr && hit(a, OFF_DRV_SET)) ? wbits : READ_ZERO;
  wire [31:0] w_drv_clr = (wr && hit(a, OFF_DRV_CLR)) ? wbits : READ_ZERO;
  wire w_drv_state = wr && hit(a, OFF_DRV_STATE);
  wire [31:0] w_irq_on = (wr && hit(a, OFF_IRQ_ON)) ? wbits : READ_ZERO;
  wire [31:0] w_irq_off = (wr && hit(a, OFF_IRQ_OFF)) ? wbits : READ_ZERO;
  wire [31:0] w_od_on = (wr && hit(a, OFF_OD_ON)) ? wbits : READ_ZERO;
  wire [31:0] w_od_off = (wr && hit(a, OFF_OD_OFF)) ? wbits : READ_ZERO;
  wire [31:0] w_pu_off = (wr && hit(a, OFF_PU_OFF)) ? wbits : READ_ZERO;
  wire [31:0] w_pu_on = (wr && hit(a, OFF_PU_ON)) ? wbits : READ_ZERO;
  wire [31:0] w_alt_a = (wr && hit(a, OFF_ALT_A)) ? wbits : READ_ZERO;
  wire [31:0] w_alt_b = (wr && hit(a, OFF_ALT_B)) ? wbits : READ_ZERO;
  wire [31:0] w_permit_on = (wr && hit(a, OFF_PERMIT_ON)) ? wbits : READ_ZERO;
  wire [31:0] w_permit_off = (wr && hit(a, OFF_PERMIT_OFF)) ? wbits : READ_ZERO;

  // Status read clears at the capture edge; new events still set
  wire rd_chg = capture && avs_read && hit(a, OFF_CHG_STATUS);

  assign out_en_nxt = (out_en_r | w_out_on) & ~w_out_off;
  assign filter_nxt = (filter_r | w_filt_on) & ~w_filt_off;
  assign drive_nxt = w_drv_state ?
                     ((drive_r & ~(permit_r & wmask)) | (wbits & permit_r)) :
                     ((drive_r | w_drv_set) & ~w_drv_clr);
  assign irq_mask_nxt = (irq_mask_r | w_irq_on) & ~w_irq_off;
  assign chg_nxt = (rd_chg ? READ_ZERO : chg_r) | (pin_changed & IMPL_MASK);
  assign od_nxt = (od_r | w_od_on) & ~w_od_off;
  assign pu_off_nxt = (pu_off_r | w_pu_off) & ~w_pu_on;
  assign alt_b_nxt = (alt_b_r | w_alt_b) & ~w_alt_a;
  assign permit_nxt = (permit_r | w_permit_on) & ~w_permit_off;

  // Read strobes, one per readable offset
  wire rs_out = hit(a, OFF_OUT_STATE);
  wire rs_filt = hit(a, OFF_FILT_STATE);
  wire rs_drv = hit(a, OFF_DRV_STATE);
  wire rs_pin = hit(a, OFF_PIN_LEVEL);
  wire rs_mask = hit(a, OFF_IRQ_MASK);
  wire rs_chg = hit(a, OFF_CHG_STATUS);
  wire rs_od = hit(a, OFF_OD_STATE);
  wire rs_pu = hit(a, OFF_PU_STATE);
  wire rs_alt = hit(a, OFF_ALT_STATE);
  wire rs_permit = hit(a, OFF_PERMIT_STATE);

  // No strobe for write-only or unmapped offsets, so they read zero
  wire [31:0] read_value = ({32{rs_out}} & out_en_r) |
                           ({32{rs_filt}} & filter_r) |
                           ({32{rs_drv}} & drive_r) |
                           ({32{rs_pin}} & pin_level & IMPL_MASK) |
                           ({32{rs_mask}} & irq_mask_r) |
                           ({32{rs_chg}} & chg_r) |
                           ({32{rs_od}} & od_r) |
                           ({32{rs_pu}} & pu_off_r) |
                           ({32{rs_alt}} & alt_b_r) |
                           ({32{rs_permit}} & permit_r);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_r <= BUS_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      readdata_r <= READ_ZERO;
    end else if (capture && avs_read) begin
      readdata_r <= read_value;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      out_en_r <= RST_LINE_REGS;
    end else begin
      out_en_r <= out_en_nxt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      filter_r <= RST_LINE_REGS;
    end else begin
      filter_r <= filter_nxt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      drive_r <= RST_LINE_REGS;
    end else begin
      drive_r <= drive_nxt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      irq_mask_r <= RST_LINE_REGS;
    end else begin
      irq_mask_r <= irq_mask_nxt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      chg_r <= RST_LINE_REGS;
    end else begin
      chg_r <= chg_nxt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      od_r <= RST_LINE_REGS;
    end else begin
      od_r <= od_nxt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      pu_off_r <= RST_LINE_REGS;
    end else begin
      pu_off_r <= pu_off_nxt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      alt_b_r <= RST_LINE_REGS;
    end else begin
      alt_b_r <= alt_b_nxt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      permit_r <= RST_LINE_REGS;
    end else begin
      permit_r <= permit_nxt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(chg_nxt & irq_mask_nxt);
    end
  end

  // Open-drain lines pull low only; push-pull lines drive both levels
  genvar i;
  generate
    for (i = 0; i < LINES; i++) begin : g_pad
      assign pad_drive.level[i] = od_r[i] ? 1'b0 : drive_r[i];
      assign pad_drive.enable[i] = out_en_r[i] & (od_r[i] ? ~drive_r[i] : 1'b1);
    end
  endgenerate

  assign line_cfg.pullup_on = ~pu_off_r & IMPL_MASK;
  assign line_cfg.periph_b = alt_b_r;
  assign line_cfg.filter_on = filter_r;
  assign irq = irq_r;

endmodule

// *** verif/pio_lines_assertions.sv ***
/*
  Concurrent checks on the ports of the parallel line controller.
  Assumes full-word writes from an Avalon-MM master.
*/
`timescale 1ns/1ps
module pio_lines_assertions
  import pio_lines_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [LINES-1:0] pad_in,
  input wire pad_drive_t pad_drive,
  input wire line_cfg_t line_cfg,
  input wire logic irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  logic [31:0] wd_r;
  always_ff @(posedge core_clk) begin
    wd_r <= avs_writedata;
  end
  sequence wr(logic [7:0] a);
    avs_write && !avs_waitrequest && avs_byteenable == 4'hF && avs_address == a;
  endsequence
  AST_ANSWER: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered after one wait cycle");
  AST_FILT_ON: assert property (wr(OFF_FILT_ON) |=> &(line_cfg.filter_on | ~wd_r))
    else $error("filter not enabled");
  AST_FILT_OFF: assert property (wr(OFF_FILT_OFF) |=> !(|(line_cfg.filter_on & wd_r)))
    else $error("filter not disabled");
  AST_KEEP: assert property (wr(OFF_FILT_ON) |=>
    (line_cfg.filter_on & ~wd_r) == ($past(line_cfg.filter_on) & ~wd_r)) else $error("unwritten line changed");
  AST_PU_OFF: assert property (wr(OFF_PU_OFF) |=> !(|(line_cfg.pullup_on & wd_r)))
    else $error("pull-up not off");
  AST_PU_ON: assert property (wr(OFF_PU_ON) |=> &(line_cfg.pullup_on | ~wd_r))
    else $error("pull-up not on");
  AST_ALT_A: assert property (wr(OFF_ALT_A) |=> !(|(line_cfg.periph_b & wd_r)))
    else $error("first function not chosen");
  AST_ALT_B: assert property (wr(OFF_ALT_B) |=> &(line_cfg.periph_b | ~wd_r))
    else $error("second function not chosen");
  AST_OD_LOW: assert property (wr(OFF_OD_ON) |=> !(|(pad_drive.level & wd_r)))
    else $error("open-drain line driven high");
  AST_IRQ_OFF: assert property (wr(OFF_IRQ_OFF) ##0 avs_writedata == 32'hFFFF_FFFF |=> ##1 !irq)
    else $error("interrupt with all lines masked");
  AST_WO_READ: assert property (avs_read && !avs_waitrequest && avs_address == OFF_DRV_SET |->
    avs_readdata == 32'h0) else $error("write-only register read nonzero");
endmodule

bind pio_lines pio_lines_assertions u_chk (
  .core_clk(core_clk),
  .srst(srst),
  .avs_address(avs_address),
  .avs_read(avs_read),
  .avs_write(avs_write),
  .avs_byteenable(avs_byteenable),
  .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest),
  .pad_in(pad_in),
  .pad_drive(pad_drive),
  .line_cfg(line_cfg),
  .irq(irq)
);

// *** verif/pad_model.sv ***
/*
  Pad model: resolves each line from the controller, an outside driver
  and the pull-up. Assumes the core clock.
*/
`timescale 1ns/1ps
module pad_model
  import pio_lines_pkg::*;
(
  input wire logic core_clk,
  input wire pad_drive_t pad_drive,
  input wire line_cfg_t line_cfg,
  input wire logic [31:0] ext_en,
  input wire logic [31:0] ext_val,
  output logic [LINES-1:0] pad_in
);
  logic [31:0] float_r = 32'h5555_5555;
  // Undriven lines without pull-up wander
  always @(posedge core_clk) begin
    float_r <= ~float_r;
  end
  assign pad_in = (pad_drive.enable & pad_drive.level)
    | (~pad_drive.enable & ((ext_en & ext_val) | (~ext_en & (line_cfg.pullup_on | float_r))));
endmodule

// *** verif/tb_pio_lines.sv ***
/*
  Self-checking bench of the parallel line controller.
  Assumes the pad model closes the pins.
*/
`timescale 1ns/1ps
module tb_pio_lines
  import pio_lines_pkg::*;
;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic [3:0] avs_byteenable = 4'hF;
  logic [3:0] bsel = 4'hF;
  logic [31:0] avs_writedata = 32'h0, ext_en = 32'h0, ext_val = 32'h0, avs_readdata, q, v1, v2, d1, d2;
  logic avs_waitrequest, irq;
  logic [LINES-1:0] pad_in;
  pad_drive_t pad_drive;
  line_cfg_t line_cfg;
  int n_mismatch = 0;
  int n_checks = 0;
  logic [7:0] on_a[7] = '{8'h20, 8'h30, 8'h40, 8'h50, 8'h64, 8'h74, 8'hA0};
  logic [7:0] off_a[7] = '{8'h24, 8'h34, 8'h44, 8'h54, 8'h60, 8'h70, 8'hA4};
  logic [7:0] st_a[7] = '{8'h28, 8'h38, 8'h48, 8'h58, 8'h68, 8'h78, 8'hA8};
  logic [31:0] st[7] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'hFFFF_FFFF, 32'h0, 32'h0};
  always #2.5 core_clk = ~core_clk;
  pio_lines dut (
    .core_clk(core_clk),
    .srst(srst),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_byteenable(avs_byteenable),
    .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .pad_in(pad_in),
    .pad_drive(pad_drive),
    .line_cfg(line_cfg),
    .irq(irq)
  );
  pad_model pads (
    .core_clk(core_clk),
    .pad_drive(pad_drive),
    .line_cfg(line_cfg),
    .ext_en(ext_en),
    .ext_val(ext_val),
    .pad_in(pad_in)
  );
  // Waits for the answer however long it takes; only the watchdog ends a hang
  task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= d;
    avs_byteenable <= bsel;
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rd(input logic [7:0] a, input string nm, input logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    chk(nm, e, q);
  endtask
  // Pull-up state reads inverted
  function automatic logic [31:0] ex(int i);
    return (i == 4) ? ~st[i] : st[i];
  endfunction
  // Bits reached by the enabled byte lanes
  function automatic logic [31:0] lanes(input logic [3:0] b);
    return {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
  endfunction
  task stop_test;
    $display("mismatches %0d checks %0d", n_mismatch, n_checks);
    if (n_mismatch == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    void'($urandom(23));
    repeat (5) @(posedge core_clk);
    srst <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      rd(st_a[i], "reset state", ex(i));
      rd(on_a[i], "write-only", 32'h0);
    end
    for (int k = 0; k < 6; k++) for (int i = 0; i < 7; i++) begin
      bsel = k[0] ? 4'($urandom) : 4'hF;
      d1 = $urandom;
      d2 = $urandom;
      bus(on_a[i], 1'b1, d1);
      bus(off_a[i], 1'b1, d2);
      st[i] = (st[i] | (d1 & lanes(bsel))) & ~(d2 & lanes(bsel));
      rd(st_a[i], "state", ex(i));
    end
    bsel = 4'hF;
    d1 = $urandom;
    bus(8'h38, 1'b1, d1);
    st[1] = (st[1] & ~st[6]) | (d1 & st[6]);
    rd(8'h38, "drive state", st[1]);
    rd(8'h7C, "unmapped", 32'h0);
    v1 = $urandom;
    ext_en <= 32'hFFFF_FFFF;
    ext_val <= v1;
    repeat (10) @(posedge core_clk);
    rd(8'h3C, "pin level", v1);
    bus(8'h4C, 1'b0, 32'h0);
    v2 = $urandom;
    ext_val <= v2;
    repeat (10) @(posedge core_clk);
    chk("irq", 32'(|((v1 ^ v2) & st[2])), 32'(irq));
    rd(8'h4C, "change", v1 ^ v2);
    rd(8'h4C, "change again", 32'h0);
    ext_val <= ~v2;
    repeat (10) @(posedge core_clk);
    chk("irq set", 32'(|st[2]), 32'(irq));
    bus(8'h44, 1'b1, 32'hFFFF_FFFF);
    repeat (3) @(posedge core_clk);
    chk("irq off", 32'h0, 32'(irq));
    rd(8'h48, "mask", 32'h0);
    rd(8'h4C, "change kept", 32'hFFFF_FFFF);
    ext_en <= 32'h0;
    bus(8'h10, 1'b1, 32'hFFFF_FFFF);
    @(posedge core_clk);
    chk("enable", ~st[3] | ~st[1], pad_drive.enable);
    chk("level", st[1] & ~st[3], pad_drive.level);
    chk("pullup", st[4], line_cfg.pullup_on);
    chk("filter", st[0], line_cfg.filter_on);
    chk("periph", st[5], line_cfg.periph_b);
    rd(8'h18, "output enable", 32'hFFFF_FFFF);
    srst <= 1'b1;
    repeat (3) @(posedge core_clk);
    srst <= 1'b0;
    repeat (8) @(posedge core_clk);
    chk("enable after reset", 32'h0, pad_drive.enable);
    rd(8'h4C, "change after reset", 32'h0);
    rd(8'h3C, "pin after reset", 32'hFFFF_FFFF);
    rd(8'h68, "pull-up after reset", 32'h0);
    stop_test();
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    n_mismatch++;
    stop_test();
  end
endmodule
